//--- src/irf_consts.svh
`ifndef IRF_CONSTS_SVH
`define IRF_CONSTS_SVH

// Register byte offsets
`define IRF_CTRL_ADDR 8'h00
`define IRF_CMD_ADDR 8'h04
`define IRF_MOD_ADDR 8'h08
`define IRF_BKL_ADDR 8'h0c
`define IRF_ENC_ADDR 8'h10
`define IRF_STAT_ADDR 8'h14
`define IRF_POS_ADDR 8'h18
`define IRF_FOLLOW_ADDR 8'h1c
`define IRF_STILL_ADDR 8'h20
`define IRF_DECEL_ADDR 8'h24
`define IRF_TPOS_BASE 8'h40
`define IRF_TSPD_BASE 8'h60

// Field positions
`define IRF_CTRL_PMODE_LSB 0
`define IRF_CTRL_AXIS_BIT 2
`define IRF_CTRL_SDIR_BIT 3
`define IRF_CTRL_RMODE_LSB 4
`define IRF_CMD_ABS_BIT 0
`define IRF_STAT_REF_BIT 0
`define IRF_STAT_ADJ_BIT 1
`define IRF_STAT_HOMED_BIT 2
`define IRF_STAT_DIR_BIT 3
`define IRF_STAT_RUN_BIT 4
`define IRF_STAT_LOCK_BIT 5

// Reset values
`define IRF_PMODE_RST 2'h0
`define IRF_AXIS_RST 1'h0
`define IRF_SDIR_RST 1'h0
`define IRF_RMODE_RST 3'h1
`define IRF_MOD_RST 32'h00057e40
`define IRF_BKL_RST 32'h00000000
`define IRF_ENC_RST 32'h00000800
`define IRF_TPOS_RST 32'h00000000
`define IRF_TSPD_RST 32'h00000258

// Value ranges
`define IRF_TPOS_MIN 32'h800003e8
`define IRF_TPOS_MAX 32'h7ffffc17
`define IRF_TSPD_MIN 32'h00000001
`define IRF_TSPD_MAX 32'h02625a00
`define IRF_MOD_MIN 32'h00000001
`define IRF_MOD_MAX 32'h7ffffc17
`define IRF_BKL_MIN 32'hfffcf2c0
`define IRF_BKL_MAX 32'h00030d40
`define IRF_RMODE_MAX 3'h4
`define IRF_DECEL_MAX 32'h001e8480

// Derived limit scaling
`define IRF_FOLLOW_SHIFT 3
`define IRF_STILL_SHIFT 4
`define IRF_DECEL_SHIFT 1

`endif

//--- src/irf_pkg.sv
package irf_pkg;
	// Bus data-phase states
	typedef enum logic [3:0] {
		IRF_DP_IDLE = 4'b0001,
		IRF_DP_WR = 4'b0010,
		IRF_DP_RWAIT = 4'b0100,
		IRF_DP_RDONE = 4'b1000
	} irf_dphase_t;

	// Positioning modes
	typedef enum logic [1:0] {
		IRF_PM_INCR = 2'h0,
		IRF_PM_ABS = 2'h1,
		IRF_PM_ABS_POS = 2'h2,
		IRF_PM_ABS_NEG = 2'h3
	} irf_pmode_t;
endpackage

//--- src/irf_target_mem.sv
`timescale 1ns/1ps
`include "irf_consts.svh"
module irf_target_mem (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Write port
	input wire logic we_i,
	input wire logic wsel_spd_i,
	input wire logic [2:0] waddr_i,
	input wire logic [31:0] wdata_i,
	// Bus read port
	input wire logic [2:0] raddr_a_i,
	input wire logic rsel_spd_a_i,
	output logic [31:0] rdata_a_o,
	// Motion read port
	input wire logic [2:0] raddr_b_i,
	output logic [31:0] rpos_b_o,
	output logic [31:0] rspd_b_o
);
	import irf_pkg::*;

	logic [31:0] tpos [8];
	logic [31:0] tspd [8];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_entry
			always_ff @(posedge clk_i) begin
				if (!rst_n_i) begin
					tpos[gi] <= `IRF_TPOS_RST;
					tspd[gi] <= `IRF_TSPD_RST;
				end else if (we_i && waddr_i == 3'(gi)) begin
					if (wsel_spd_i) begin
						tspd[gi] <= wdata_i;
					end else begin
						tpos[gi] <= wdata_i;
					end
				end
			end
		end
	endgenerate

	// Registered read ports
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rdata_a_o <= 32'h0;
			rpos_b_o <= 32'h0;
			rspd_b_o <= 32'h0;
		end else begin
			rdata_a_o <= rsel_spd_a_i ? tspd[raddr_a_i] : tpos[raddr_a_i];
			rpos_b_o <= tpos[raddr_b_i];
			rspd_b_o <= tspd[raddr_b_i];
		end
	end
endmodule

//--- src/irf_top.sv
`timescale 1ns/1ps
`include "irf_consts.svh"
module irf_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	// Drive pins
	input wire logic reference_input_i,
	input wire logic referencing_start_input_i,
	input wire logic enc_step_i,
	input wire logic enc_dir_i,
	input wire logic internal_position_mode_i,
	input wire logic abs_encoder_i,
	// Motion side
	input wire logic [2:0] tgt_sel_i,
	output logic [31:0] fixed_target_position_o,
	output logic [31:0] fixed_target_speed_o,
	output logic [31:0] act_pos_o,
	output irf_pkg::irf_pmode_t eff_pos_mode_o,
	output logic referenced_o,
	output logic homing_run_o,
	output logic [2:0] referencing_mode_o,
	output logic [31:0] max_decel_limit_o
);
	import irf_pkg::*;

	irf_dphase_t dph;
	logic [7:0] dph_addr;
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic [2:0] prev;
	logic [1:0] positioning_mode_sel;
	logic axis_type_sel;
	logic search_start_direction;
	logic [2:0] referencing_mode_sel;
	logic [31:0] modulo_range;
	logic [31:0] backlash_amount;
	logic [31:0] enc_res;
	logic [31:0] follow_limit;
	logic [31:0] still_limit;
	logic [31:0] rd_reg;
	logic rd_mem;
	logic [31:0] mem_rdata;
	logic referenced;
	logic adjusted;
	logic last_dir;
	logic homing_run;
	logic [31:0] act_pos;
	logic [31:0] next_pos;
	logic addr_take;
	logic wr_en;
	logic wr_ctrl;
	logic wr_mod;
	logic abs_cmd;
	logic ref_s;
	logic referencing_start_input_s;
	logic step_s;
	logic dir_s;
	logic internal_position_mode_s;
	logic absenc_s;
	logic ref_edge;
	logic referencing_start_input_edge;
	logic step_ev;
	logic zero_ev;
	logic homed;
	logic rmode_lock;
	logic [2:0] new_rmode;
	logic mem_we;
	logic signed [32:0] acc;
	logic signed [32:0] bkl_ext;
	logic signed [32:0] mod_ext;

	// Input synchronisers, two stages each
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync1 <= 6'h0;
			sync2 <= 6'h0;
		end else begin
			sync1 <= {abs_encoder_i, internal_position_mode_i, enc_dir_i, enc_step_i,
				referencing_start_input_i, reference_input_i};
			sync2 <= sync1;
		end
	end

	assign ref_s = sync2[0];
	assign referencing_start_input_s = sync2[1];
	assign step_s = sync2[2];
	assign dir_s = sync2[3];
	assign internal_position_mode_s = sync2[4];
	assign absenc_s = sync2[5];

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prev <= 3'h0;
		end else begin
			prev <= {step_s, referencing_start_input_s, ref_s};
		end
	end

	assign ref_edge = ref_s && !prev[0];
	assign referencing_start_input_edge = referencing_start_input_s && !prev[1];
	assign step_ev = step_s && !prev[2];

	// Bus address phase and write strobes
	assign addr_take = hsel_i && htrans_i[1] && hready_i;
	assign wr_en = (dph == IRF_DP_WR);
	assign wr_ctrl = wr_en && dph_addr == `IRF_CTRL_ADDR;
	assign wr_mod = wr_en && dph_addr == `IRF_MOD_ADDR;
	assign abs_cmd = wr_en && dph_addr == `IRF_CMD_ADDR && hwdata_i[`IRF_CMD_ABS_BIT] && absenc_s;
	assign mem_we = wr_en && dph_addr[7:6] == 2'h1 && (dph_addr[5]
		? (hwdata_i >= `IRF_TSPD_MIN && hwdata_i <= `IRF_TSPD_MAX)
		: ($signed(hwdata_i) >= $signed(`IRF_TPOS_MIN)
		&& $signed(hwdata_i) <= $signed(`IRF_TPOS_MAX)));

	// Reads take one wait state so prior writes are seen
	assign hreadyout_o = (dph != IRF_DP_RWAIT);
	assign hresp_o = 1'b0;
	assign hrdata_o = rd_mem ? mem_rdata : rd_reg;

	// Data-phase state machine
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			dph <= IRF_DP_IDLE;
			dph_addr <= 8'h0;
		end else begin
			case (dph)
				IRF_DP_RWAIT: begin
					dph <= IRF_DP_RDONE;
				end
				default: begin
					if (addr_take) begin
						dph <= hwrite_i ? IRF_DP_WR : IRF_DP_RWAIT;
						dph_addr <= {haddr_i[7:2], 2'h0};
					end else begin
						dph <= IRF_DP_IDLE;
					end
				end
			endcase
		end
	end

	// Read data capture, unmapped reads as zero
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			rd_reg <= 32'h0;
			rd_mem <= 1'b0;
		end else if (dph == IRF_DP_RWAIT) begin
			rd_mem <= (dph_addr[7:6] == 2'h1);
			if (dph_addr == `IRF_CTRL_ADDR) begin
				rd_reg <= {25'h0, referencing_mode_sel, search_start_direction,
					axis_type_sel, positioning_mode_sel};
			end else if (dph_addr == `IRF_MOD_ADDR) begin
				rd_reg <= modulo_range;
			end else if (dph_addr == `IRF_BKL_ADDR) begin
				rd_reg <= backlash_amount;
			end else if (dph_addr == `IRF_ENC_ADDR) begin
				rd_reg <= enc_res;
			end else if (dph_addr == `IRF_STAT_ADDR) begin
				rd_reg <= {26'h0, rmode_lock, homing_run, last_dir, homed, adjusted, referenced};
			end else if (dph_addr == `IRF_POS_ADDR) begin
				rd_reg <= act_pos;
			end else if (dph_addr == `IRF_FOLLOW_ADDR) begin
				rd_reg <= follow_limit;
			end else if (dph_addr == `IRF_STILL_ADDR) begin
				rd_reg <= still_limit;
			end else if (dph_addr == `IRF_DECEL_ADDR) begin
				rd_reg <= max_decel_limit_o;
			end else begin
				rd_reg <= 32'h0;
			end
		end
	end

	// Target table
	irf_target_mem u_mem (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.we_i(mem_we),
		.wsel_spd_i(dph_addr[5]),
		.waddr_i(dph_addr[4:2]),
		.wdata_i(hwdata_i),
		.raddr_a_i(dph_addr[4:2]),
		.rsel_spd_a_i(dph_addr[5]),
		.rdata_a_o(mem_rdata),
		.raddr_b_i(tgt_sel_i),
		.rpos_b_o(fixed_target_position_o),
		.rspd_b_o(fixed_target_speed_o)
	);

	// Homed status and referencing mode lock
	assign homed = absenc_s ? adjusted : referenced;
	assign rmode_lock = absenc_s && adjusted;
	assign new_rmode = hwdata_i[`IRF_CTRL_RMODE_LSB +: 3];

	// Configuration registers
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			positioning_mode_sel <= `IRF_PMODE_RST;
			axis_type_sel <= `IRF_AXIS_RST;
			search_start_direction <= `IRF_SDIR_RST;
			referencing_mode_sel <= `IRF_RMODE_RST;
		end else if (wr_ctrl) begin
			positioning_mode_sel <= hwdata_i[`IRF_CTRL_PMODE_LSB +: 2];
			axis_type_sel <= hwdata_i[`IRF_CTRL_AXIS_BIT];
			search_start_direction <= hwdata_i[`IRF_CTRL_SDIR_BIT];
			if (internal_position_mode_s && new_rmode <= `IRF_RMODE_MAX && !(rmode_lock && new_rmode != 3'h0)) begin
				referencing_mode_sel <= new_rmode;
			end
		end
	end

	// Range-checked numeric settings
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			modulo_range <= `IRF_MOD_RST;
			backlash_amount <= `IRF_BKL_RST;
			enc_res <= `IRF_ENC_RST;
		end else if (wr_en) begin
			if (dph_addr == `IRF_MOD_ADDR && hwdata_i >= `IRF_MOD_MIN
				&& hwdata_i <= `IRF_MOD_MAX) begin
				modulo_range <= hwdata_i;
			end
			if (dph_addr == `IRF_BKL_ADDR && $signed(hwdata_i) >= $signed(`IRF_BKL_MIN)
				&& $signed(hwdata_i) <= $signed(`IRF_BKL_MAX)) begin
				backlash_amount <= hwdata_i;
			end
			if (dph_addr == `IRF_ENC_ADDR && hwdata_i != 32'h0) begin
				enc_res <= hwdata_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			follow_limit <= 32'h0;
			still_limit <= 32'h0;
			max_decel_limit_o <= 32'h0;
		end else begin
			follow_limit <= enc_res << `IRF_FOLLOW_SHIFT;
			still_limit <= (enc_res >> `IRF_STILL_SHIFT) | 32'h1;
			max_decel_limit_o <= ((enc_res << `IRF_DECEL_SHIFT) > `IRF_DECEL_MAX)
				? `IRF_DECEL_MAX : (enc_res << `IRF_DECEL_SHIFT);
		end
	end

	assign zero_ev = ref_edge && internal_position_mode_s && referencing_mode_sel == 3'h0;

	// Referenced and adjusted flags, set wins over clear
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			referenced <= 1'b0;
			adjusted <= 1'b0;
		end else begin
			if (wr_ctrl && hwdata_i[`IRF_CTRL_AXIS_BIT] != axis_type_sel) begin
				referenced <= 1'b0;
			end
			if (zero_ev) begin
				referenced <= 1'b1;
			end
			if (abs_cmd) begin
				adjusted <= 1'b1;
			end
		end
	end

	// Position arithmetic
	assign bkl_ext = {backlash_amount[31], backlash_amount};
	assign mod_ext = {1'b0, modulo_range};
	always_comb begin
		acc = {act_pos[31], act_pos};
		if (step_ev) begin
			acc = dir_s ? acc + 33'sd1 : acc - 33'sd1;
			if (homed && dir_s != last_dir) begin
				acc = dir_s ? acc + bkl_ext : acc - bkl_ext;
			end
		end
		if (axis_type_sel) begin
			if (acc >= mod_ext) begin
				acc = acc - mod_ext;
			end else if (acc < 33'sd0) begin
				acc = acc + mod_ext;
			end
		end
		if (zero_ev || abs_cmd) begin
			acc = 33'sd0;
		end
		next_pos = acc[31:0];
	end

	// Actual position register
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			act_pos <= 32'h0;
		end else begin
			act_pos <= next_pos;
		end
	end

	// Traversing direction memory
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			last_dir <= 1'b0;
		end else if (zero_ev || abs_cmd) begin
			last_dir <= search_start_direction;
		end else if (step_ev) begin
			last_dir <= dir_s;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			homing_run <= 1'b0;
		end else if (!referencing_start_input_s) begin
			homing_run <= 1'b0;
		end else if (referencing_start_input_edge && internal_position_mode_s && referencing_mode_sel != 3'h0 && !rmode_lock) begin
			homing_run <= 1'b1;
		end
	end

	always_comb begin
		if (!homed) begin
			eff_pos_mode_o = IRF_PM_INCR;
		end else if (positioning_mode_sel[1] && !axis_type_sel) begin
			eff_pos_mode_o = IRF_PM_ABS;
		end else begin
			eff_pos_mode_o = irf_pmode_t'(positioning_mode_sel);
		end
	end

	assign act_pos_o = act_pos;
	assign referenced_o = homed;
	assign homing_run_o = homing_run;
	assign referencing_mode_o = referencing_mode_sel;

	// Assertions
	a_zero_on_ref: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		zero_ev |=> act_pos == 32'h0 && referenced)
		else $error("position not zeroed by reference edge");
	a_rmode_locked: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_ctrl && !internal_position_mode_s |=> $stable(referencing_mode_sel))
		else $error("referencing mode changed outside position mode");
	a_abs_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		eff_pos_mode_o != IRF_PM_INCR |-> homed)
		else $error("absolute mode while not homed");
	a_abs_lock: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		rmode_lock && wr_ctrl && new_rmode != 3'h0 |=> $stable(referencing_mode_sel))
		else $error("locked referencing mode accepted");
	a_modulo_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		axis_type_sel && !homed && !wr_en && act_pos < modulo_range && !act_pos[31]
		|=> act_pos < modulo_range && !act_pos[31])
		else $error("modulo position left its range");
	a_no_bkl_unhomed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		step_ev && dir_s && !homed && !axis_type_sel && !zero_ev && !abs_cmd
		|=> act_pos == $past(act_pos) + 32'h1)
		else $error("backlash applied before homing");
	a_bkl_apply: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		step_ev && dir_s && !last_dir && homed && !axis_type_sel && !zero_ev && !abs_cmd
		|=> act_pos == $past(act_pos) + 32'h1 + $past(backlash_amount))
		else $error("backlash not applied on reversal");
	a_dir_armed: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		zero_ev |=> last_dir == $past(search_start_direction))
		else $error("direction not armed after referencing");
	a_run_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		homing_run && !referencing_start_input_s |=> !homing_run)
		else $error("search run kept with start input low");
	a_axis_reref: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		wr_ctrl && hwdata_i[`IRF_CTRL_AXIS_BIT] != axis_type_sel && !zero_ev
		|=> !referenced)
		else $error("referenced kept after axis change");
endmodule

//--- test/irf_drive_model.sv
`timescale 1ns/1ps
module irf_drive_model (
	// Clock
	input wire logic clk_i,
	// Drive pins
	output logic enc_step_o,
	output logic enc_dir_o,
	output logic reference_input_o,
	output logic referencing_start_input_o
);
	initial begin
		enc_step_o = 1'b0;
		enc_dir_o = 1'b1;
		reference_input_o = 1'b0;
		referencing_start_input_o = 1'b0;
	end

	// Step pulses, direction settled well before the edge
	task automatic move(input logic dir, input int n);
		for (int k = 0; k < n; k++) begin
			@(posedge clk_i) enc_dir_o <= dir;
			repeat (2) @(posedge clk_i);
			enc_step_o <= 1'b1;
			repeat (4) @(posedge clk_i);
			enc_step_o <= 1'b0;
			repeat (4) @(posedge clk_i);
		end
	endtask

	// reference only at standstill
	// Called only between moves, so the motor never steps meanwhile
	task automatic set_ref(input logic v);
		@(posedge clk_i) reference_input_o <= v;
		repeat (5) @(posedge clk_i);
	endtask

	task automatic set_start(input logic v);
		@(posedge clk_i) referencing_start_input_o <= v;
		repeat (5) @(posedge clk_i);
	endtask
endmodule

//--- test/irf_top_tb.sv
`timescale 1ns/1ps
`include "irf_consts.svh"
module irf_top_tb;
	import irf_pkg::*;
	logic clk_i, rst_n_i, hsel_i, hwrite_i, hready, ipm, abs_enc;
	logic [31:0] haddr_i, hwdata_i, hrdata_o, x;
	logic [1:0] htrans_i;
	logic [2:0] tgt_sel_i, rmode, hsize;
	logic ref_in, start_in, step, dir, hresp, refd, run;
	logic [31:0] tpos, tspd, pos, decel;
	irf_pmode_t eff;
	int error_cnt = 0;
	int checks = 0;

	// Clock
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	irf_top i_irf_top (.clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
		.htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize), .hwdata_i(hwdata_i),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata_o),
		.reference_input_i(ref_in), .referencing_start_input_i(start_in),
		.enc_step_i(step), .enc_dir_i(dir), .internal_position_mode_i(ipm),
		.abs_encoder_i(abs_enc), .tgt_sel_i(tgt_sel_i), .fixed_target_position_o(tpos),
		.fixed_target_speed_o(tspd), .act_pos_o(pos), .eff_pos_mode_o(eff),
		.referenced_o(refd), .homing_run_o(run), .referencing_mode_o(rmode),
		.max_decel_limit_o(decel));

	irf_drive_model i_irf_drive_model (.clk_i(clk_i), .enc_step_o(step), .enc_dir_o(dir),
		.reference_input_o(ref_in), .referencing_start_input_o(start_in));

	task automatic finish_test();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, e, g);
		end
	endtask

	// Wait for hready sampled high at a rising edge, bounded; data taken at that edge
	task automatic wait_ready(output logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		while (hready !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		if (hready !== 1'b1) begin
			error_cnt++;
			$display("MISMATCH hready expected 1 seen timeout");
			finish_test();
		end else begin
			d = hrdata_o;
		end
	endtask

	// One single-word transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk_i);
		hsel_i <= 1'b1;
		haddr_i <= a;
		htrans_i <= 2'h2;
		hwrite_i <= w;
		hsize <= 3'h2;
		wait_ready(r);
		hsel_i <= 1'b0;
		htrans_i <= 2'h0;
		hwdata_i <= d;
		wait_ready(r);
		// Let the landed write settle before outputs are compared
		@(negedge clk_i);
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, x);
	endtask

	task automatic rc(input string name, input logic [31:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, x);
		chk(name, e, x);
	endtask

	function automatic logic [31:0] ta(input logic [7:0] base, input int i);
		return {24'h0, base} + 32'(4 * i);
	endfunction

	initial begin
		rst_n_i = 1'b0;
		hsel_i = 1'b0;
		haddr_i = 32'h0;
		htrans_i = 2'h0;
		hwrite_i = 1'b0;
		hsize = 3'h0;
		hwdata_i = 32'h0;
		ipm = 1'b0;
		abs_enc = 1'b0;
		tgt_sel_i = 3'h0;
		repeat (6) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		// Reset values and derived limits
		rc("ctrl", {24'h0, `IRF_CTRL_ADDR}, {25'h0, `IRF_RMODE_RST, 4'h0});
		rc("modulo", {24'h0, `IRF_MOD_ADDR}, `IRF_MOD_RST);
		rc("backlash", {24'h0, `IRF_BKL_ADDR}, `IRF_BKL_RST);
		rc("follow", {24'h0, `IRF_FOLLOW_ADDR}, `IRF_ENC_RST << `IRF_FOLLOW_SHIFT);
		rc("still", {24'h0, `IRF_STILL_ADDR}, (`IRF_ENC_RST >> `IRF_STILL_SHIFT) | 32'h1);
		chk("decel", `IRF_ENC_RST << `IRF_DECEL_SHIFT, decel);
		chk("eff_mode", 32'h0, {30'h0, eff});
		for (int i = 0; i < 8; i++) begin
			rc("tpos", ta(`IRF_TPOS_BASE, i), `IRF_TPOS_RST);
			rc("tspd", ta(`IRF_TSPD_BASE, i), `IRF_TSPD_RST);
			wr(ta(`IRF_TPOS_BASE, i), `IRF_TPOS_MIN + 32'(i));
			wr(ta(`IRF_TSPD_BASE, i), `IRF_TSPD_MAX - 32'(i));
		end
		// Out-of-range values are dropped
		wr(ta(`IRF_TPOS_BASE, 0), 32'h80000000);
		wr(ta(`IRF_TSPD_BASE, 1), 32'h0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_i) tgt_sel_i <= 3'(i);
			repeat (2) @(posedge clk_i);
			chk("tpos_out", `IRF_TPOS_MIN + 32'(i), tpos);
			chk("tspd_out", `IRF_TSPD_MAX - 32'(i), tspd);
		end
		wr(32'h30, 32'hffffffff);
		rc("unmapped", 32'h30, 32'h0);
		// Referencing mode outside position mode is refused
		wr({24'h0, `IRF_CTRL_ADDR}, 32'h0);
		rc("ctrl_ipm", {24'h0, `IRF_CTRL_ADDR}, 32'h10);
		@(posedge clk_i) ipm <= 1'b1;
		repeat (4) @(posedge clk_i);
		for (int r = 0; r < 6; r++) begin
			wr({24'h0, `IRF_CTRL_ADDR}, 32'(r) << 4);
			rc("ctrl_rmode", {24'h0, `IRF_CTRL_ADDR}, 32'(r < 5 ? r : 4) << 4);
		end
		// Homing run follows the start input
		wr({24'h0, `IRF_CTRL_ADDR}, 32'h10);
		i_irf_drive_model.set_start(1'b1);
		chk("run_on", 32'h1, {31'h0, run});
		i_irf_drive_model.set_start(1'b0);
		chk("run_off", 32'h0, {31'h0, run});
		// Mode 0, absolute requested, backlash 5, start direction negative
		wr({24'h0, `IRF_BKL_ADDR}, 32'h5);
		wr({24'h0, `IRF_BKL_ADDR}, `IRF_BKL_MAX + 32'h1);
		rc("bkl_keep", {24'h0, `IRF_BKL_ADDR}, 32'h5);
		wr({24'h0, `IRF_CTRL_ADDR}, 32'h1);
		chk("eff_unref", 32'h0, {30'h0, eff});
		i_irf_drive_model.move(1'b1, 3);
		i_irf_drive_model.move(1'b0, 1);
		chk("pos_nobkl", 32'h2, pos);
		i_irf_drive_model.set_ref(1'b1);
		chk("pos_zero", 32'h0, pos);
		chk("referenced", 32'h1, {31'h0, refd});
		chk("eff_abs", 32'h1, {30'h0, eff});
		i_irf_drive_model.set_ref(1'b0);
		i_irf_drive_model.move(1'b1, 1);
		chk("pos_rev1", 32'h6, pos);
		i_irf_drive_model.move(1'b1, 1);
		chk("pos_fwd", 32'h7, pos);
		i_irf_drive_model.move(1'b0, 1);
		chk("pos_rev2", 32'h1, pos);
		wr({24'h0, `IRF_CTRL_ADDR}, 32'h2);
		chk("eff_lin2", 32'h1, {30'h0, eff});
		// Modulo axis of range 10
		wr({24'h0, `IRF_BKL_ADDR}, 32'h0);
		wr({24'h0, `IRF_MOD_ADDR}, 32'ha);
		wr({24'h0, `IRF_CTRL_ADDR}, 32'h6);
		chk("unref_axis", 32'h0, {31'h0, refd});
		i_irf_drive_model.set_ref(1'b1);
		i_irf_drive_model.set_ref(1'b0);
		i_irf_drive_model.move(1'b0, 1);
		chk("wrap_down", 32'h9, pos);
		chk("eff_pos", 32'h2, {30'h0, eff});
		i_irf_drive_model.move(1'b1, 1);
		chk("wrap_up", 32'h0, pos);
		wr({24'h0, `IRF_CTRL_ADDR}, 32'h7);
		chk("eff_neg", 32'h3, {30'h0, eff});
		// Absolute encoder adjust locks referencing modes other than 0
		i_irf_drive_model.move(1'b1, 1);
		@(posedge clk_i) abs_enc <= 1'b1;
		repeat (4) @(posedge clk_i);
		wr({24'h0, `IRF_CMD_ADDR}, 32'h1);
		repeat (2) @(posedge clk_i);
		chk("pos_adj", 32'h0, pos);
		chk("adjusted", 32'h1, {31'h0, refd});
		wr({24'h0, `IRF_CTRL_ADDR}, 32'h27);
		rc("ctrl_lock", {24'h0, `IRF_CTRL_ADDR}, 32'h7);
		chk("rmode_lock", 32'h0, {29'h0, rmode});
		rc("status", {24'h0, `IRF_STAT_ADDR}, 32'h27);
		rc("pos_reg", {24'h0, `IRF_POS_ADDR}, 32'h0);
		// New resolution, zero refused, decel clamped
		wr({24'h0, `IRF_ENC_ADDR}, 32'h00200000);
		wr({24'h0, `IRF_ENC_ADDR}, 32'h0);
		rc("enc", {24'h0, `IRF_ENC_ADDR}, 32'h00200000);
		rc("follow_new", {24'h0, `IRF_FOLLOW_ADDR}, 32'h00200000 << `IRF_FOLLOW_SHIFT);
		rc("decel_clamp", {24'h0, `IRF_DECEL_ADDR}, `IRF_DECEL_MAX);
		chk("hresp", 32'h0, {31'h0, hresp});
		finish_test();
	end
endmodule
